/* core/scgc_defines.svh */
// constants for the system clock generator control block
// assumes one 125 MHz clock and an 8-bit special-function register port
//
// Behaviour
// - after any reset the cpu runs from the fast internal oscillator
// - main oscillator or external main clock stops on stop instruction or halt bit 7
// - fast internal oscillator stops on stop instruction or halt bit 0
// - fast internal frequency comes from option byte, software may change it later
// - main clock is high-speed system clock or fast internal, chosen by bit 4
// - sub oscillator or external sub clock stops when halt bit 6 is set
// - slow internal oscillator can never become the cpu clock
// - slow internal oscillator runs when watchdog option or low-speed select is 1
// - watchdog only, no standby option: slow oscillator stops on halt or stop
// - mode register takes one 8-bit write after reset, reads only 8-bit
// - mode register resets to 00H; sub pin and drive bits only on power-on
// - main pin field 00/10 port, 01 crystal, 11 external clock
// - sub pin field 00/10 port, 01 sub crystal, 11 external sub clock
// - sub drive 00 low power, 01 normal, 10 ultra-low, 11 prohibited
// - main gain bit 0 for 1 to 10 MHz, 1 above 10 up to 20 MHz
// - mode register at FFFA0H, reset 00H, fields 7:6, 5:4, 3 zero, 2:1, 0
// - clock select register at FFFA4H, reset 00H, bit or byte access
// - cpu source bit 0 main, 1 sub; status flag reports the source in use
// - main status flag 0 for fast internal, 1 for high-speed system clock
// - clock status and main status flags are read-only
`ifndef SCGC_DEFINES_SVH
`define SCGC_DEFINES_SVH
`define SCGC_ADDR_W 20
`define SCGC_PIN_MODE_ADDR 20'hFFFA0
`define SCGC_CLK_SEL_ADDR 20'hFFFA4
`define SCGC_OSC_RUN_ADDR 20'hFFFA1
`define SCGC_SUB_SUPPLY_ADDR 20'hFFFA5
`define SCGC_FAST_DIV_ADDR 20'hFFFA8
`define SCGC_PIN_MODE_RESET 8'h00
`define SCGC_CLK_SEL_RESET 8'h00
`define SCGC_OSC_RUN_RESET 8'hC0
`define SCGC_SUB_SUPPLY_RESET 8'h00
`define SCGC_MAIN_FIELD_HI 7
`define SCGC_MAIN_FIELD_LO 6
`define SCGC_SUB_FIELD_HI 5
`define SCGC_SUB_FIELD_LO 4
`define SCGC_DRIVE_HI 2
`define SCGC_DRIVE_LO 1
`define SCGC_GAIN_BIT 0
`define SCGC_PIN_MODE_MASK 8'hF7
`define SCGC_CLS_BIT 7
`define SCGC_CSS_BIT 6
`define SCGC_MCS_BIT 5
`define SCGC_MCM_BIT 4
`define SCGC_MAIN_HALT_BIT 7
`define SCGC_SUB_HALT_BIT 6
`define SCGC_FAST_HALT_BIT 0
`define SCGC_LOW_SEL_BIT 4
`define SCGC_WDT_EN_BIT 4
`define SCGC_WDT_STBY_BIT 0
`define SCGC_FAST_DIV_W 3
`endif

/* core/scgc_pkg.sv */
// types for the system clock generator control block
// assumes scgc_defines.svh for the numbers
`include "scgc_defines.svh"
package scgc_pkg;
    typedef enum logic [1:0] {
        SCGC_PIN_PORT,
        SCGC_PIN_CRYSTAL,
        SCGC_PIN_EXT_CLOCK
    } scgc_pin_mode_t;
    typedef enum logic [1:0] {
        SCGC_DRIVE_LOW_POWER,
        SCGC_DRIVE_NORMAL,
        SCGC_DRIVE_ULTRA_LOW,
        SCGC_DRIVE_PROHIBITED
    } scgc_drive_t;
    typedef enum logic [1:0] {
        SCGC_CPU_FAST_INTERNAL,
        SCGC_CPU_HIGH_SPEED,
        SCGC_CPU_SUB
    } scgc_cpu_src_t;
    typedef enum logic [2:0] {
        SCGC_FREQ_24M,
        SCGC_FREQ_16M,
        SCGC_FREQ_12M,
        SCGC_FREQ_8M,
        SCGC_FREQ_6M,
        SCGC_FREQ_4M,
        SCGC_FREQ_3M,
        SCGC_FREQ_2M
    } scgc_fast_freq_t;
endpackage : scgc_pkg

/* core/scgc_pin_sync.sv */
// three-stage synchroniser with agreement filter
// assumes a single asynchronous input bit and the block clock
`timescale 1ns/1ns
module scgc_pin_sync (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic async_in,
    output logic level_out
);
    import scgc_pkg::*;
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } scgc_sync_st_t;
    scgc_sync_st_t st_q;
    scgc_sync_st_t st_d;
    always_comb begin
        st_d = st_q;
        st_d.stage = {st_q.stage[1:0], async_in};
        if (st_q.stage[1] == st_q.stage[2]) begin
            st_d.level = st_q.stage[2];
        end
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else if (ce_in) begin
            st_q <= st_d;
        end
    end
    assign level_out = st_q.level;
endmodule // scgc_pin_sync

/* core/scgc_clock_control.sv */
// system clock generator control: mode, select, run and supply registers
// assumes an 8-bit register port from the cpu and oscillators outside
`timescale 1ns/1ns
`include "scgc_defines.svh"
module scgc_clock_control (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic por_in,
    input wire logic ce_in,
    input wire logic [`SCGC_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_byte_in,
    input wire logic [2:0] reg_bit_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] option_wdt_in,
    input wire logic [2:0] option_freq_in,
    input wire logic stop_exec_in,
    input wire logic halt_exec_in,
    input wire logic sub_clock_ok_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic main_osc_run_out,
    output logic sub_osc_run_out,
    output logic fast_osc_run_out,
    output logic slow_osc_run_out,
    output scgc_pkg::scgc_pin_mode_t main_pin_mode_out,
    output scgc_pkg::scgc_pin_mode_t sub_pin_mode_out,
    output scgc_pkg::scgc_drive_t sub_drive_out,
    output logic main_gain_out,
    output scgc_pkg::scgc_fast_freq_t fast_freq_out,
    output scgc_pkg::scgc_cpu_src_t cpu_src_out
);
    import scgc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic scgc_pin_mode_t pin_decode(input logic [1:0] f);
        unique case (f)
            2'h1: pin_decode = SCGC_PIN_CRYSTAL;
            2'h3: pin_decode = SCGC_PIN_EXT_CLOCK;
            default: pin_decode = SCGC_PIN_PORT;
        endcase
    endfunction

    function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [7:0] wd,
            input logic byte_acc, input logic [2:0] bsel);
        logic [7:0] r;
        r = old;
        if (byte_acc) begin
            r = wd;
        end else begin
            r[bsel] = wd[bsel];
        end
        bit_merge = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] pin_mode;
        logic pin_mode_locked;
        logic cpu_src_sel;
        logic main_src_sel;
        logic cpu_src_stat;
        logic main_src_stat;
        logic main_halt;
        logic sub_halt;
        logic fast_halt;
        logic low_sel;
        logic [2:0] fast_div;
        logic strap_taken;
        logic [7:0] rdata;
        logic ack;
        logic main_run;
        logic sub_run;
        logic fast_run;
        logic slow_run;
        logic [1:0] cpu_src;
        logic stop_mode;
        logic [1:0] main_pin;
        logic [1:0] sub_pin;
    } scgc_state_t;

    scgc_state_t st_q;
    scgc_state_t st_d;
    scgc_state_t live_q;
    logic [6:0] keep_q;
    logic sub_ok;
    logic wr_pin;
    logic wr_sel;
    logic wr_run;
    logic wr_sup;
    logic wr_div;
    logic main_ready;
    logic [7:0] sel_view;
    logic [7:0] run_view;
    logic [7:0] sup_view;
    logic wdt_en;
    logic wdt_stby;

    scgc_pin_sync sub_sync_inst (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in(sub_clock_ok_in),
        .level_out(sub_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register access

    assign wr_pin = reg_wr_in && reg_addr_in == `SCGC_PIN_MODE_ADDR;
    assign wr_sel = reg_wr_in && reg_addr_in == `SCGC_CLK_SEL_ADDR;
    assign wr_run = reg_wr_in && reg_addr_in == `SCGC_OSC_RUN_ADDR;
    assign wr_sup = reg_wr_in && reg_addr_in == `SCGC_SUB_SUPPLY_ADDR;
    assign wr_div = reg_wr_in && reg_addr_in == `SCGC_FAST_DIV_ADDR;
    assign wdt_en = option_wdt_in[`SCGC_WDT_EN_BIT];
    assign wdt_stby = option_wdt_in[`SCGC_WDT_STBY_BIT];
    assign main_ready = st_q.main_pin != SCGC_PIN_PORT && st_q.main_run;

    always_comb begin
        sel_view = 8'h00;
        sel_view[`SCGC_CLS_BIT] = st_q.cpu_src_stat;
        sel_view[`SCGC_CSS_BIT] = st_q.cpu_src_sel;
        sel_view[`SCGC_MCS_BIT] = st_q.main_src_stat;
        sel_view[`SCGC_MCM_BIT] = st_q.main_src_sel;
        run_view = 8'h00;
        run_view[`SCGC_MAIN_HALT_BIT] = st_q.main_halt;
        run_view[`SCGC_SUB_HALT_BIT] = st_q.sub_halt;
        run_view[`SCGC_FAST_HALT_BIT] = st_q.fast_halt;
        sup_view = 8'h00;
        sup_view[`SCGC_LOW_SEL_BIT] = st_q.low_sel;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0] nv;
        nv = 8'h00;
        st_d = st_q;
        st_d.ack = reg_wr_in || reg_rd_in;
        st_d.rdata = 8'h00;
        if (!st_q.strap_taken) begin
            st_d.strap_taken = 1'b1;
            st_d.fast_div = option_freq_in;
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `SCGC_PIN_MODE_ADDR: st_d.rdata = reg_byte_in ? st_q.pin_mode : 8'h00;
                `SCGC_CLK_SEL_ADDR: st_d.rdata = sel_view;
                `SCGC_OSC_RUN_ADDR: st_d.rdata = run_view;
                `SCGC_SUB_SUPPLY_ADDR: st_d.rdata = sup_view;
                `SCGC_FAST_DIV_ADDR: st_d.rdata = {5'h00, st_q.fast_div};
                default: st_d.rdata = 8'h00;
            endcase
        end
        if (wr_pin && reg_byte_in && !st_q.pin_mode_locked) begin
            st_d.pin_mode = reg_wdata_in & `SCGC_PIN_MODE_MASK;
            st_d.pin_mode_locked = 1'b1;
        end
        if (wr_sel) begin
            nv = bit_merge(sel_view, reg_wdata_in, reg_byte_in, reg_bit_in);
            st_d.cpu_src_sel = nv[`SCGC_CSS_BIT];
            st_d.main_src_sel = nv[`SCGC_MCM_BIT];
        end
        if (wr_run) begin
            nv = bit_merge(run_view, reg_wdata_in, reg_byte_in, reg_bit_in);
            st_d.main_halt = nv[`SCGC_MAIN_HALT_BIT];
            st_d.sub_halt = nv[`SCGC_SUB_HALT_BIT];
            st_d.fast_halt = nv[`SCGC_FAST_HALT_BIT];
        end
        if (wr_sup) begin
            nv = bit_merge(sup_view, reg_wdata_in, reg_byte_in, reg_bit_in);
            st_d.low_sel = nv[`SCGC_LOW_SEL_BIT];
        end
        if (wr_div && reg_wdata_in[2:0] != 3'h7) begin
            st_d.fast_div = reg_wdata_in[2:0];
        end
        if (stop_exec_in) begin
            st_d.stop_mode = 1'b1;
        end else if (reg_wr_in || reg_rd_in) begin
            st_d.stop_mode = 1'b0;
        end
        // status follows select only once the target source is alive; cpu status returns to main at once
        if (st_q.main_src_sel && main_ready) begin
            st_d.main_src_stat = 1'b1;
        end else if (!st_q.main_src_sel && st_q.fast_run) begin
            st_d.main_src_stat = 1'b0;
        end
        if (st_q.cpu_src_sel && st_q.sub_run && sub_ok) begin
            st_d.cpu_src_stat = 1'b1;
        end else if (!st_q.cpu_src_sel) begin
            st_d.cpu_src_stat = 1'b0;
        end
        st_d.main_pin = pin_decode(st_d.pin_mode[`SCGC_MAIN_FIELD_HI:`SCGC_MAIN_FIELD_LO]);
        st_d.sub_pin = pin_decode(st_d.pin_mode[`SCGC_SUB_FIELD_HI:`SCGC_SUB_FIELD_LO]);
        st_d.main_run = !st_d.main_halt && !st_d.stop_mode
            && st_d.main_pin != SCGC_PIN_PORT;
        st_d.fast_run = !st_d.fast_halt && !st_d.stop_mode;
        st_d.sub_run = !st_d.sub_halt && st_d.sub_pin != SCGC_PIN_PORT;
        st_d.slow_run = (wdt_en || st_d.low_sel)
            && !(wdt_en && !st_d.low_sel && !wdt_stby
            && (st_d.stop_mode || halt_exec_in));
        // slow oscillator is never a cpu source: only three encodings exist
        if (st_d.cpu_src_stat) begin
            st_d.cpu_src = 2'(SCGC_CPU_SUB);
        end else if (st_d.main_src_stat) begin
            st_d.cpu_src = 2'(SCGC_CPU_HIGH_SPEED);
        end else begin
            st_d.cpu_src = 2'(SCGC_CPU_FAST_INTERNAL);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; power-on keeps sub pin and drive fields otherwise

    // state view: power-on-only bits override their copies in live_q
    always_comb begin
        st_q = live_q;
        st_q.pin_mode[5:4] = keep_q[6:5];
        st_q.pin_mode[2:1] = keep_q[4:3];
        st_q.sub_halt = keep_q[2];
        st_q.sub_pin = keep_q[1:0];
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            live_q <= '{main_halt: 1'b1, fast_run: 1'b1, default: '0};
        end else if (ce_in) begin
            live_q <= st_d;
        end
    end

    // power-on-only domain: sub pin field, sub drive field, sub halt, sub pin decode
    always_ff @(posedge clk_sys_in or posedge por_in) begin
        if (por_in) begin
            keep_q <= 7'h04;
        end else if (ce_in) begin
            keep_q <= {st_d.pin_mode[5:4], st_d.pin_mode[2:1], st_d.sub_halt, st_d.sub_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_out = st_q.rdata;
    assign reg_ack_out = st_q.ack;
    assign main_osc_run_out = st_q.main_run;
    assign sub_osc_run_out = st_q.sub_run;
    assign fast_osc_run_out = st_q.fast_run;
    assign slow_osc_run_out = st_q.slow_run;
    assign main_pin_mode_out = scgc_pin_mode_t'(st_q.main_pin);
    assign sub_pin_mode_out = scgc_pin_mode_t'(st_q.sub_pin);
    assign sub_drive_out =
        scgc_drive_t'(st_q.pin_mode[`SCGC_DRIVE_HI:`SCGC_DRIVE_LO]);
    assign main_gain_out = st_q.pin_mode[`SCGC_GAIN_BIT];
    assign fast_freq_out = scgc_fast_freq_t'(st_q.fast_div);
    assign cpu_src_out = scgc_cpu_src_t'(st_q.cpu_src);
endmodule // scgc_clock_control

/* dv/scgc_sub_clock_source.sv */
// model of the sub clock source on the sub pins, reporting a settled clock
// assumes the block's sub oscillator enable and the block clock for timing
`timescale 1ns/1ns
module scgc_sub_clock_source #(
    parameter int SETTLE_CYC = 8
) (
    input wire logic clk_sys_in,
    input wire logic run_in,
    output logic ok_out
);
    int cnt_q = 0;
    always @(posedge clk_sys_in) begin
        if (!run_in) begin
            cnt_q <= 0;
        end else if (cnt_q < SETTLE_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end
    // no clock while disabled, so the present flag drops at once
    assign ok_out = run_in && (cnt_q >= SETTLE_CYC);
endmodule // scgc_sub_clock_source

/* dv/scgc_clock_control_properties.sv */
// concurrent checks on the clock control block ports
// assumes scgc_defines.svh and a bind onto every instance of the block
`timescale 1ns/1ns
`include "scgc_defines.svh"
module scgc_clock_control_properties (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [`SCGC_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_byte_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] option_wdt_in,
    input wire logic stop_exec_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_ack_out,
    input wire logic main_osc_run_out,
    input wire logic sub_osc_run_out,
    input wire logic fast_osc_run_out,
    input wire logic slow_osc_run_out,
    input wire scgc_pkg::scgc_pin_mode_t main_pin_mode_out,
    input wire scgc_pkg::scgc_drive_t sub_drive_out,
    input wire logic main_gain_out,
    input wire scgc_pkg::scgc_cpu_src_t cpu_src_out
);
    import scgc_pkg::*;
    logic written_q;
    logic rd_sel_q;
    wire wr_any = ce_in && reg_wr_in && reg_byte_in;
    wire wr_mode = wr_any && reg_addr_in == `SCGC_PIN_MODE_ADDR;
    wire wr_run = wr_any && reg_addr_in == `SCGC_OSC_RUN_ADDR;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            written_q <= 1'h0;
            rd_sel_q <= 1'h0;
        end else begin
            written_q <= written_q || wr_mode;
            rd_sel_q <= ce_in && reg_rd_in && reg_addr_in == `SCGC_CLK_SEL_ADDR;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    property p_ack;
        ce_in && (reg_wr_in || reg_rd_in) |=> reg_ack_out;
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge");
    property p_reset_fast;
        $fell(rst_in) |-> cpu_src_out == SCGC_CPU_FAST_INTERNAL && fast_osc_run_out;
    endproperty
    a_reset_fast: assert property (p_reset_fast) else $error("not on fast clock");
    property p_never_slow;
        cpu_src_out != 2'h3;
    endproperty
    a_never_slow: assert property (p_never_slow) else $error("bad cpu source");
    property p_first_write;
        wr_mode && !written_q |=> main_gain_out == $past(reg_wdata_in[0])
            && sub_drive_out == $past(reg_wdata_in[2:1]);
    endproperty
    a_first_write: assert property (p_first_write) else $error("mode not taken");
    property p_ext_decode;
        wr_mode && !written_q && reg_wdata_in[7:6] == 2'h3
            |=> main_pin_mode_out == SCGC_PIN_EXT_CLOCK;
    endproperty
    a_ext_decode: assert property (p_ext_decode) else $error("main decode");
    property p_write_once;
        wr_mode && written_q |=> $stable(main_gain_out) && $stable(sub_drive_out)
            && $stable(main_pin_mode_out);
    endproperty
    a_write_once: assert property (p_write_once) else $error("mode rewritten");
    property p_bit_write;
        ce_in && reg_wr_in && !reg_byte_in && reg_addr_in == `SCGC_PIN_MODE_ADDR
            |=> $stable(main_gain_out) && $stable(main_pin_mode_out);
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write took");
    property p_main_halt;
        wr_run && reg_wdata_in[7] |-> ##[1:2] !main_osc_run_out;
    endproperty
    a_main_halt: assert property (p_main_halt) else $error("main not halted");
    property p_fast_halt;
        wr_run && reg_wdata_in[0] |-> ##[1:2] !fast_osc_run_out;
    endproperty
    a_fast_halt: assert property (p_fast_halt) else $error("fast not halted");
    property p_sub_halt;
        wr_run && reg_wdata_in[6] |-> ##[1:2] !sub_osc_run_out;
    endproperty
    a_sub_halt: assert property (p_sub_halt) else $error("sub not halted");
    property p_stop;
        ce_in && stop_exec_in |-> ##[1:2] !main_osc_run_out && !fast_osc_run_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_slow_wdt;
        (option_wdt_in[4] && option_wdt_in[0]) [*3] |-> slow_osc_run_out;
    endproperty
    a_slow_wdt: assert property (p_slow_wdt) else $error("slow not running");
    property p_sel_zero;
        rd_sel_q && reg_ack_out |-> reg_rdata_out[3:0] == 4'h0;
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("select low bits");
    c_rewrite: cover property (wr_mode && written_q);
    c_sub: cover property (cpu_src_out == SCGC_CPU_SUB);
    c_stop: cover property (ce_in && stop_exec_in);
endmodule // scgc_clock_control_properties

bind scgc_clock_control scgc_clock_control_properties chk (.clk_sys_in, .rst_in, .ce_in,
    .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_byte_in, .reg_wdata_in, .option_wdt_in,
    .stop_exec_in, .reg_rdata_out, .reg_ack_out, .main_osc_run_out, .sub_osc_run_out,
    .fast_osc_run_out, .slow_osc_run_out, .main_pin_mode_out, .sub_drive_out,
    .main_gain_out, .cpu_src_out);

/* dv/system_clock_generator_control_tb.sv */
// self-checking bench for the clock control block
// assumes the design files, the sub clock model and the checker
`timescale 1ns/1ns
`include "scgc_defines.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module system_clock_generator_control_tb;
    import scgc_pkg::*;
    localparam logic [19:0] addr_pin = `SCGC_PIN_MODE_ADDR;
    localparam logic [19:0] addr_sel = `SCGC_CLK_SEL_ADDR;
    localparam logic [19:0] addr_run = `SCGC_OSC_RUN_ADDR;
    localparam logic [19:0] addr_sub = `SCGC_SUB_SUPPLY_ADDR;
    localparam logic [19:0] addr_div = `SCGC_FAST_DIV_ADDR;
    logic clk_sys_in = 1'h0, rst_in = 1'h1, por_in = 1'h1, ce_in = 1'h1;
    logic [`SCGC_ADDR_W-1:0] reg_addr_in = '0;
    logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, reg_byte_in = 1'h1;
    logic [2:0] reg_bit_in = 3'h0, option_freq_in = 3'h2;
    logic [7:0] reg_wdata_in = 8'h00, option_wdt_in = 8'h00, reg_rdata_out, rd_val;
    logic stop_exec_in = 1'h0, halt_exec_in = 1'h0, sub_clock_ok_in, reg_ack_out;
    logic main_osc_run_out, sub_osc_run_out, fast_osc_run_out, slow_osc_run_out;
    logic main_gain_out;
    scgc_pin_mode_t main_pin_mode_out, sub_pin_mode_out;
    scgc_drive_t sub_drive_out;
    scgc_fast_freq_t fast_freq_out;
    scgc_cpu_src_t cpu_src_out;
    int error_cnt = 0, num_checks = 0;
    always #4 clk_sys_in = ~clk_sys_in;
    scgc_clock_control dut (.clk_sys_in, .rst_in, .por_in, .ce_in, .reg_addr_in, .reg_wr_in,
        .reg_rd_in, .reg_byte_in, .reg_bit_in, .reg_wdata_in, .option_wdt_in, .option_freq_in,
        .stop_exec_in, .halt_exec_in, .sub_clock_ok_in, .reg_rdata_out, .reg_ack_out,
        .main_osc_run_out, .sub_osc_run_out, .fast_osc_run_out, .slow_osc_run_out,
        .main_pin_mode_out, .sub_pin_mode_out, .sub_drive_out, .main_gain_out,
        .fast_freq_out, .cpu_src_out);
    scgc_sub_clock_source #(.SETTLE_CYC(6)) partner (.clk_sys_in, .run_in(sub_osc_run_out),
        .ok_out(sub_clock_ok_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic do_reset(input logic p);
        @(negedge clk_sys_in);
        rst_in = 1'h1;
        por_in = p;
        repeat (10) @(negedge clk_sys_in);
        rst_in = 1'h0;
        por_in = 1'h0;
        @(negedge clk_sys_in);
    endtask
    // one-cycle strobe, then wait for the acknowledge pulse
    task automatic acc(input logic w, input logic [19:0] a, input logic [7:0] d,
                       input logic b = 1'h1);
        int n;
        @(negedge clk_sys_in);
        reg_wr_in = w;
        reg_rd_in = !w;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_byte_in = b;
        @(negedge clk_sys_in);
        reg_wr_in = 1'h0;
        reg_rd_in = 1'h0;
        for (n = 0; n < 4 && reg_ack_out !== 1'h1; n++) @(negedge clk_sys_in);
        if (reg_ack_out !== 1'h1) begin
            error_cnt++;
            final_report();
        end
        rd_val = reg_rdata_out;
    endtask
    task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
        acc(1'h0, a, 8'h00);
        `CHK($sformatf("reg %h", a), e, rd_val)
    endtask
    task automatic poll_src(input scgc_cpu_src_t e);
        int n;
        for (n = 0; n < 20 && cpu_src_out !== e; n++) @(negedge clk_sys_in);
        `CHK("cpu src", e, cpu_src_out)
        if (cpu_src_out !== e) begin
            final_report();
        end
    endtask
    task automatic slow_chk(input logic [7:0] w, input logic h, input logic e);
        option_wdt_in = w;
        halt_exec_in = h;
        repeat (2) @(negedge clk_sys_in);
        `CHK("slow run", e, slow_osc_run_out)
    endtask
    function automatic scgc_pin_mode_t pm_of(input logic [1:0] f);
        return f == 2'h1 ? SCGC_PIN_CRYSTAL : f == 2'h3 ? SCGC_PIN_EXT_CLOCK : SCGC_PIN_PORT;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'h1);
        rd_chk(addr_pin, 8'h00);
        rd_chk(addr_sel, 8'h00);
        rd_chk(addr_run, 8'hC0);
        rd_chk(20'hFFFB0, 8'h00);
        `CHK("cpu src", SCGC_CPU_FAST_INTERNAL, cpu_src_out)
        `CHK("fast run", 1'h1, fast_osc_run_out)
        `CHK("fast freq", scgc_fast_freq_t'(3'h2), fast_freq_out)
        acc(1'h1, addr_sel, 8'hA0);
        rd_chk(addr_sel, 8'h00);
        acc(1'h1, addr_pin, 8'hFF, 1'h0);
        rd_chk(addr_pin, 8'h00);
        acc(1'h1, addr_pin, 8'h5B);
        rd_chk(addr_pin, 8'h53);
        `CHK("gain", 1'h1, main_gain_out)
        acc(1'h0, addr_pin, 8'h00, 1'h0);
        `CHK("bit read", 8'h00, rd_val)
        acc(1'h1, addr_pin, 8'hC0);
        rd_chk(addr_pin, 8'h53);
        acc(1'h1, addr_run, 8'h40);
        acc(1'h1, addr_sel, 8'h10);
        poll_src(SCGC_CPU_HIGH_SPEED);
        rd_chk(addr_sel, 8'h30);
        acc(1'h1, addr_run, 8'h41);
        @(negedge clk_sys_in);
        `CHK("fast run", 1'h0, fast_osc_run_out)
        acc(1'h1, addr_run, 8'h01);
        acc(1'h1, addr_sel, 8'h50);
        poll_src(SCGC_CPU_SUB);
        rd_chk(addr_sel, 8'hF0);
        acc(1'h1, addr_sel, 8'h10);
        poll_src(SCGC_CPU_HIGH_SPEED);
        acc(1'h1, addr_run, 8'h41);
        @(negedge clk_sys_in);
        `CHK("sub run", 1'h0, sub_osc_run_out)
        do_reset(1'h0);
        `CHK("cpu src", SCGC_CPU_FAST_INTERNAL, cpu_src_out)
        rd_chk(addr_pin, 8'h12);
        acc(1'h1, addr_pin, 8'h53);
        acc(1'h1, addr_run, 8'h40);
        @(negedge clk_sys_in);
        `CHK("main run", 1'h1, main_osc_run_out)
        stop_exec_in = 1'h1;
        @(negedge clk_sys_in);
        stop_exec_in = 1'h0;
        @(negedge clk_sys_in);
        `CHK("main run", 1'h0, main_osc_run_out)
        `CHK("fast run", 1'h0, fast_osc_run_out)
        acc(1'h1, addr_run, 8'hC0);
        @(negedge clk_sys_in);
        `CHK("main run", 1'h0, main_osc_run_out)
        `CHK("fast run", 1'h1, fast_osc_run_out)
        slow_chk(8'h10, 1'h0, 1'h1);
        slow_chk(8'h10, 1'h1, 1'h0);
        slow_chk(8'h11, 1'h1, 1'h1);
        acc(1'h1, addr_sub, 8'h10);
        slow_chk(8'h00, 1'h1, 1'h1);
        acc(1'h1, addr_sub, 8'h00);
        slow_chk(8'h00, 1'h0, 1'h0);
        acc(1'h1, addr_div, 8'h05);
        @(negedge clk_sys_in);
        `CHK("fast freq", scgc_fast_freq_t'(3'h5), fast_freq_out)
        acc(1'h1, addr_div, 8'h07);
        @(negedge clk_sys_in);
        `CHK("fast freq", scgc_fast_freq_t'(3'h5), fast_freq_out)
        ce_in = 1'h0;
        stop_exec_in = 1'h1;
        repeat (2) @(negedge clk_sys_in);
        `CHK("fast run", 1'h1, fast_osc_run_out)
        stop_exec_in = 1'h0;
        ce_in = 1'h1;
        for (int k = 0; k < 4; k++) begin
            do_reset(1'h1);
            acc(1'h1, addr_pin, {k[1:0], k[1:0], 1'h0, k[1:0], 1'h0});
            `CHK("main pin", pm_of(k[1:0]), main_pin_mode_out)
            `CHK("sub pin", pm_of(k[1:0]), sub_pin_mode_out)
            `CHK("drive", scgc_drive_t'(k[1:0]), sub_drive_out)
        end
        final_report();
    end
endmodule // system_clock_generator_control_tb
